// ==== rcs_pkg.sv ====
// Package for the radio coexistence signalling block
package rcs_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] RCS_CTRL_OFS = 8'h00;
  localparam logic [7:0] RCS_PRIO_OFS = 8'h04;
  localparam logic [7:0] RCS_STAT_OFS = 8'h08;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RCS_GATE_BIT = 0;
  localparam int RCS_ENA_BIT = 1;
  localparam int RCS_MAC_BIT = 0;
  localparam int RCS_ST_ACT_BIT = 0;
  localparam int RCS_ST_PRI_BIT = 1;
  localparam int RCS_ST_EXTA_BIT = 2;
  localparam int RCS_ST_EXTB_BIT = 3;
  localparam int RCS_ST_BUSY_BIT = 4;
  localparam int RCS_ST_SUPP_BIT = 5;

  // ----------------------------------------
  // Reset values and pin function codes
  // ----------------------------------------
  localparam logic RCS_GATE_RST = 1'b0;
  localparam logic RCS_ENA_RST = 1'b0;
  localparam logic RCS_MAC_RST = 1'b1;
  localparam logic [5:0] RCS_FN_EXT_A = 6'h30;
  localparam logic [5:0] RCS_FN_EXT_B = 6'h31;
  localparam logic [5:0] RCS_FN_ACT = 6'h32;
  localparam logic [5:0] RCS_FN_PRI = 6'h33;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {RCS_IDLE, RCS_EVENT, RCS_DRAIN} rcs_phase_t;

  typedef struct packed {
    logic [1:0] ext_meta;
    logic [1:0] ext_sync;
    logic gating;
    logic enable;
    logic mac_precedence;
    rcs_phase_t phase;
    logic act_out;
    logic pri_out;
    logic suppress;
    logic [31:0] prdata;
  } rcs_state_t;

  typedef struct packed {
    logic event_envelope;
    logic activity_done;
  } rcs_radio_t;

endpackage : rcs_pkg

// ==== rcs_top.sv ====
// Radio coexistence signalling: activity/priority outputs, external sensing, APB regs
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module rcs_top
  import rcs_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Local radio
  input wire rcs_radio_t RADIO_IN,
  output logic RADIO_SUPPRESS,
  // External radios
  input wire logic EXTERNAL_ACTIVITY_IN_A,
  input wire logic EXTERNAL_ACTIVITY_IN_B,
  // Coexistence outputs
  output logic LOCAL_ACTIVITY_OUT,
  output logic LOCAL_PRIORITY_OUT
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  rcs_state_t st_reg;
  rcs_state_t st_next;
  logic ext_any;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic want_act;
  logic want_pri;

  function automatic logic rcs_hit(input logic [7:0] a);
    rcs_hit = (a == RCS_CTRL_OFS) || (a == RCS_PRIO_OFS) || (a == RCS_STAT_OFS);
  endfunction

  // ----------------------------------------
  // Combinational next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.ext_meta = {EXTERNAL_ACTIVITY_IN_B, EXTERNAL_ACTIVITY_IN_A};
    st_next.ext_sync = st_reg.ext_meta;
    ext_any = |st_reg.ext_sync;
    addr_ok = rcs_hit(PADDR);
    wr_en = PSEL && PENABLE && PWRITE && addr_ok;
    rd_en = PSEL && !PENABLE && !PWRITE;
    if (wr_en && PADDR == RCS_CTRL_OFS) begin
      st_next.gating = PWDATA[RCS_GATE_BIT];
      st_next.enable = PWDATA[RCS_ENA_BIT];
    end
    if (wr_en && PADDR == RCS_PRIO_OFS) begin
      st_next.mac_precedence = PWDATA[RCS_MAC_BIT];
    end
    unique case (st_reg.phase)
      RCS_IDLE: begin
        if (RADIO_IN.event_envelope) begin
          st_next.phase = RCS_EVENT;
        end
      end
      RCS_EVENT: begin
        if (!RADIO_IN.event_envelope) begin
          st_next.phase = RADIO_IN.activity_done ? RCS_IDLE : RCS_DRAIN;
        end
      end
      RCS_DRAIN: begin
        if (RADIO_IN.activity_done) begin
          st_next.phase = RADIO_IN.event_envelope ? RCS_EVENT : RCS_IDLE;
        end
      end
      default: st_next.phase = RCS_IDLE;
    endcase
    want_act = st_reg.enable && (RADIO_IN.event_envelope || st_next.phase != RCS_IDLE);
    want_pri = 1'b0;
    st_next.suppress = 1'b0;
    if (!st_reg.gating) begin
      want_pri = want_act && (st_reg.mac_precedence || !ext_any);
    end else if (st_reg.mac_precedence) begin
      want_pri = want_act;
    end else begin
      st_next.suppress = st_reg.enable && ext_any;
      if (ext_any) begin
        want_act = 1'b0;
      end
      want_pri = 1'b0;
    end
    st_next.act_out = want_act;
    st_next.pri_out = want_pri;
    if (rd_en) begin
      st_next.prdata = '0;
      if (PADDR == RCS_CTRL_OFS) begin
        st_next.prdata[RCS_GATE_BIT] = st_reg.gating;
        st_next.prdata[RCS_ENA_BIT] = st_reg.enable;
      end else if (PADDR == RCS_PRIO_OFS) begin
        st_next.prdata[RCS_MAC_BIT] = st_reg.mac_precedence;
      end else if (PADDR == RCS_STAT_OFS) begin
        st_next.prdata[RCS_ST_ACT_BIT] = st_reg.act_out;
        st_next.prdata[RCS_ST_PRI_BIT] = st_reg.pri_out;
        st_next.prdata[RCS_ST_EXTA_BIT] = st_reg.ext_sync[0];
        st_next.prdata[RCS_ST_EXTB_BIT] = st_reg.ext_sync[1];
        st_next.prdata[RCS_ST_BUSY_BIT] = (st_reg.phase != RCS_IDLE);
        st_next.prdata[RCS_ST_SUPP_BIT] = st_reg.suppress;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_reg <= '0;
      st_reg.gating <= RCS_GATE_RST;
      st_reg.enable <= RCS_ENA_RST;
      st_reg.mac_precedence <= RCS_MAC_RST;
      st_reg.phase <= RCS_IDLE;
    end else if (CLK_EN) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Read data captured in setup, so access answers with zero wait
  assign PRDATA = st_reg.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign LOCAL_ACTIVITY_OUT = st_reg.act_out;
  assign LOCAL_PRIORITY_OUT = st_reg.pri_out;
  assign RADIO_SUPPRESS = st_reg.suppress;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  AST_SYNC_TWO: assert property (CLK_EN [*3] |-> st_reg.ext_sync[0] == $past(EXTERNAL_ACTIVITY_IN_A, 2))
    else $error("external input not delayed two stages");
  AST_ENV_RISE: assert property (CLK_EN && st_reg.enable && !st_reg.gating && RADIO_IN.event_envelope |=> !CLK_EN || LOCAL_ACTIVITY_OUT)
    else $error("activity did not rise with envelope");
  AST_UNGATED: assert property (CLK_EN && st_reg.enable && !st_reg.gating && RADIO_IN.event_envelope && ext_any && !st_reg.mac_precedence |=> !CLK_EN || LOCAL_ACTIVITY_OUT)
    else $error("ungated activity blocked");
  AST_HOLD_DRAIN: assert property (CLK_EN && st_reg.phase == RCS_DRAIN && !RADIO_IN.activity_done && st_reg.enable && (st_reg.gating ? st_reg.mac_precedence : 1'b1) |=> !CLK_EN || LOCAL_ACTIVITY_OUT)
    else $error("activity fell before completion");
  AST_YIELD: assert property (CLK_EN && st_reg.gating && !st_reg.mac_precedence && ext_any |=> !CLK_EN || (!LOCAL_ACTIVITY_OUT && !LOCAL_PRIORITY_OUT))
    else $error("outputs not dropped under external activity");
  AST_SUPPRESS: assert property (CLK_EN && st_reg.enable && st_reg.gating && !st_reg.mac_precedence && ext_any |=> !CLK_EN || RADIO_SUPPRESS)
    else $error("local radio not suppressed");
  AST_TOGETHER: assert property (st_reg.gating && st_reg.mac_precedence && $rose(LOCAL_ACTIVITY_OUT) |-> $rose(LOCAL_PRIORITY_OUT))
    else $error("priority not raised with activity");
  AST_MIRROR: assert property (!$past(st_reg.gating) && $past(st_reg.mac_precedence) && $past(CLK_EN) |-> LOCAL_PRIORITY_OUT == LOCAL_ACTIVITY_OUT)
    else $error("priority does not mirror activity");
  AST_EXT_DROP: assert property (CLK_EN && !st_reg.gating && !st_reg.mac_precedence && ext_any |=> !CLK_EN || !LOCAL_PRIORITY_OUT)
    else $error("priority held under external activity");
  AST_PRI_IMPLIES_ACT: assert property (LOCAL_PRIORITY_OUT |-> LOCAL_ACTIVITY_OUT)
    else $error("priority without activity");
  AST_CTRL_WRITE: assert property (CLK_EN && PSEL && PENABLE && PWRITE && PADDR == RCS_CTRL_OFS |=> st_reg.gating == $past(PWDATA[RCS_GATE_BIT]))
    else $error("control write lost");

  COV_UNGATED_EVENT: cover property (!st_reg.gating && $rose(LOCAL_ACTIVITY_OUT));
  COV_DRAIN: cover property (st_reg.phase == RCS_DRAIN ##1 st_reg.phase == RCS_IDLE);
  COV_YIELD: cover property (RADIO_SUPPRESS);
  COV_GATED_BOTH: cover property (st_reg.gating && LOCAL_PRIORITY_OUT);

endmodule : rcs_top

`default_nettype wire

// ==== rcs_ext_model.sv ====
// Behavioural model of the two external radios
`timescale 1ns/10ps
`default_nettype none

module rcs_ext_model (
  // Clock
  input wire logic clk,
  // Claims commanded by the bench
  input wire logic claim_a,
  input wire logic claim_b,
  // Activity lines towards the block
  output logic act_a,
  output logic act_b
);
  // ----------------------------------------
  // Activity lines
  // ----------------------------------------
  // raise first, hold while claiming
  always @(posedge clk) begin
    act_a <= claim_a;
    act_b <= claim_b;
  end
endmodule // rcs_ext_model

`default_nettype wire

// ==== rcs_tb_top.sv ====
// Self-checking bench for the radio coexistence signalling block
`timescale 1ns/10ps
`default_nettype none

module rcs_tb_top;
  import rcs_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic claim_a = 1'b0;
  logic claim_b = 1'b0;
  logic clk_en = 1'b1;
  rcs_radio_t radio = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, suppress, act, pri, ext_a, ext_b;
  int miscompares = 0;
  int tests_run = 0;

  always #5 sys_clk = ~sys_clk;

  rcs_top i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(clk_en), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RADIO_IN(radio), .RADIO_SUPPRESS(suppress),
    .EXTERNAL_ACTIVITY_IN_A(ext_a), .EXTERNAL_ACTIVITY_IN_B(ext_b),
    .LOCAL_ACTIVITY_OUT(act), .LOCAL_PRIORITY_OUT(pri));

  rcs_ext_model i_ext (.clk(sys_clk), .claim_a(claim_a), .claim_b(claim_b), .act_a(ext_a),
    .act_b(ext_b));

  // ----------------------------------------
  // Bench tasks
  // ----------------------------------------
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // No wait-state count assumed; watchdog bounds the wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic cfg(input logic [31:0] ctrl, input logic [31:0] prio);
    apb(1'b1, RCS_CTRL_OFS, ctrl);
    apb(1'b1, RCS_PRIO_OFS, prio);
  endtask

  // In: envelope, done, claim a, claim b; out: activity, priority, suppress
  task automatic drv(input logic [3:0] in, input logic [2:0] exp);
    radio <= in[3:2];
    claim_a <= in[1];
    claim_b <= in[0];
    // Model edge plus sync stages plus output register; look between edges
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("outputs", {29'h0, exp}, {29'h0, act, pri, suppress});
    @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    test_done;
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk("ctrl", RCS_CTRL_OFS, 32'h0);
    rdchk("prio", RCS_PRIO_OFS, 32'h1);
    rdchk("stat", RCS_STAT_OFS, 32'h0);
    rdchk("hole", 8'h0c, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, RCS_STAT_OFS, 32'hffffffff);
    rdchk("stat_ro", RCS_STAT_OFS, 32'h0);
    $display("Test registers done");
    cfg(32'h0, 32'h1);
    drv(4'b1000, 3'b000);
    cfg(32'h2, 32'h1);
    drv(4'b1000, 3'b110);
    drv(4'b0000, 3'b110);
    drv(4'b0100, 3'b000);
    cfg(32'h2, 32'h0);
    drv(4'b1010, 3'b100);
    drv(4'b1000, 3'b110);
    drv(4'b0100, 3'b000);
    $display("Test gating off done");
    cfg(32'h3, 32'h1);
    drv(4'b1010, 3'b110);
    drv(4'b0100, 3'b000);
    $display("Test gating local done");
    cfg(32'h3, 32'h0);
    drv(4'b1001, 3'b001);
    apb(1'b0, RCS_STAT_OFS, 32'h0);
    chk("stat_ext", 32'h28, rd & 32'h2f);
    drv(4'b1010, 3'b001);
    drv(4'b1000, 3'b100);
    drv(4'b0100, 3'b000);
    $display("Test gating external done");
    // Frozen state while the clock enable is low
    clk_en <= 1'b0;
    drv(4'b1000, 3'b000);
    clk_en <= 1'b1;
    drv(4'b1000, 3'b100);
    drv(4'b0100, 3'b000);
    $display("Test clock enable done");
    test_done;
  end
endmodule // rcs_tb_top

`default_nettype wire
